/* dv/smbcfg_checker.sv */
// Purpose: port assertions for the config slave
// Assumes: bound onto smbcfg_slave
// Notes: address checks start once straps are caught
`default_nettype none
module smbcfg_checker
   import smbcfg_pkg::*;
#(
   parameter int                 DEPTH     = 16,
   parameter logic [3*DEPTH-1:0] TYPES     = '0,
   parameter logic [8*DEPTH-1:0] RESET_VAL = '0
) (
   input wire logic               clk_i,
   input wire logic               rst_n_i,
   input wire logic               cfg_rst_i,
   input wire logic               scl_i,
   input wire logic               scl_o,
   input wire logic               scl_oe_n_o,
   input wire logic               sda_o,
   input wire logic               sda_oe_n_o,
   input wire logic [DEPTH-1:0]   hw_load_i,
   input wire logic [8*DEPTH-1:0] hw_data_i,
   input wire logic [8*DEPTH-1:0] hw_set_i,
   input wire logic [8*DEPTH-1:0] cfg_o,
   input wire logic [6:0]         addr_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   logic [3:0] age; // edges since reset release, saturating
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) age <= 4'h0;
      else if (age != 4'hF) age <= age + 4'h1;
   end
   AST_NO_CLK_DRIVE: assert property (scl_oe_n_o && !scl_o)
      else $error("clock line driven");
   AST_SDA_PULL_ONLY: assert property (!sda_o)
      else $error("data line driven high");
   AST_SDA_MOVES_CLK_LOW: assert property ($changed(sda_oe_n_o) |-> !scl_i)
      else $error("data moved while clock high");
   AST_ADDR_HI: assert property (age > 4'h6 |-> addr_o[6:3] == SMBCFG_ADDR_HI)
      else $error("fixed address bits wrong");
   AST_ADDR_HOLD: assert property (age > 4'h6 |-> $stable(addr_o))
      else $error("address moved");
   AST_SET_WINS: assert property (!cfg_rst_i
      |=> (cfg_o & $past(hw_set_i)) == $past(hw_set_i)) else $error("event bit lost");
   for (genvar i = 0; i < DEPTH; i++) begin : g_byte
      localparam logic [2:0] TY = TYPES[3*i +: 3];
      AST_CFG_RST_CLEARS: assert property (cfg_rst_i && TY < SMBCFG_T_SW1C && !hw_load_i[i]
         |=> cfg_o[8*i +: 8] == RESET_VAL[8*i +: 8]) else $error("byte not reset");
      AST_STICKY_KEEPS: assert property (cfg_rst_i && TY >= SMBCFG_T_SW1C && !hw_load_i[i]
         && sda_oe_n_o && hw_set_i[8*i +: 8] == 8'h00 |=> $stable(cfg_o[8*i +: 8]))
         else $error("sticky byte lost");
      AST_HW_LOAD: assert property (hw_load_i[i] && !cfg_rst_i
         && hw_set_i[8*i +: 8] == 8'h00 |=> cfg_o[8*i +: 8] == $past(hw_data_i[8*i +: 8]))
         else $error("load missed");
   end
endmodule : smbcfg_checker
`default_nettype wire

/* dv/smbcfg_master.sv */
// Purpose: bus master model on the management bus
// Assumes: pull-ups on both lines, 80 ns bus clock
// Notes: bus clock stands high between frames
`default_nettype none
module smbcfg_master (
   input  wire logic clk_i,
   input  wire logic sda_i,     // resolved data line
   output var  logic scl_low_o, // pulls clock line low
   output var  logic sda_low_o  // pulls data line low
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      scl_low_o = 1'b0;
      sda_low_o = 1'b0;
   end
   task automatic w(input int n); repeat (n) @(posedge clk_i); endtask : w
   // start or repeated start, clock left low
   // clock stays low four cycles first so the target can drop its ack
   task automatic start();
      w(2);
      sda_low_o <= 1'b0;
      w(2);
      scl_low_o <= 1'b0;
      w(4);
      sda_low_o <= 1'b1;
      w(4);
      scl_low_o <= 1'b1;
   endtask : start
   // one bit: data set mid-low, sampled at end of high
   task automatic bitx(input logic b, output logic r);
      w(2);
      sda_low_o <= !b;
      w(2);
      scl_low_o <= 1'b0;
      w(4);
      r = sda_i;
      scl_low_o <= 1'b1;
   endtask : bitx
   task automatic xbyte(input logic [7:0] tx, input logic mack, output logic [7:0] rx,
                        output logic ack);
      for (int k = 7; k >= 0; k--) bitx(tx[k], rx[k]);
      bitx(mack, ack);
   endtask : xbyte
   task automatic stop();
      w(2);
      sda_low_o <= 1'b1;
      w(2);
      scl_low_o <= 1'b0;
      w(4);
      sda_low_o <= 1'b0;
      w(4);
   endtask : stop
endmodule : smbcfg_master
`default_nettype wire

/* dv/testbench.sv */
// Purpose: self-checking bench for the config slave
// Assumes: eight bytes, every access type, read/write on bytes 0 and 7
// Notes: master model drives the bus
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import smbcfg_pkg::*;
   localparam int D = 8;
   localparam logic [3*D-1:0] TY = {SMBCFG_T_RW, SMBCFG_T_SRO, SMBCFG_T_SRW, SMBCFG_T_SW1C,
                                    SMBCFG_T_W1C, SMBCFG_T_HWI, SMBCFG_T_RO, SMBCFG_T_RW};
   localparam logic [8*D-1:0] RV = 64'h8877_6655_4433_2211;
   localparam logic [6:0] MY_A = 7'h6D; // straps 5 at reset
   logic clk_i, rst_n_i, cfg_rst_i, scl, sda, m_scl, m_sda, scl_o, scl_oe_n_o, sda_o, sda_oe_n_o;
   logic [2:0] strap;
   logic [D-1:0] hw_load;
   logic [8*D-1:0] hw_data, hw_set, cfg;
   logic [6:0] addr;
   logic [7:0] ex [D]; // expected contents
   logic [7:0] rx;
   logic ak;
   int n_mismatch, tests_run, cyc;
   assign scl = !(m_scl || !scl_oe_n_o && !scl_o);
   assign sda = !(m_sda || !sda_oe_n_o && !sda_o);
   smbcfg_slave #(.DEPTH(D), .TYPES(TY), .RESET_VAL(RV)) smbcfg_slave_inst (.clk_i, .rst_n_i,
      .cfg_rst_i, .scl_i(scl), .scl_o, .scl_oe_n_o, .sda_i(sda), .sda_o, .sda_oe_n_o,
      .strap_i(strap), .hw_load_i(hw_load), .hw_data_i(hw_data), .hw_set_i(hw_set),
      .cfg_o(cfg), .addr_o(addr));
   smbcfg_master smbcfg_master_inst (.clk_i, .sda_i(sda), .scl_low_o(m_scl), .sda_low_o(m_sda));
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         n_mismatch++;
         close_out();
      end
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic close_out();
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : close_out
   function automatic logic [7:0] nxt(input logic [2:0] t, input logic [7:0] o, d);
      if (t == SMBCFG_T_W1C || t == SMBCFG_T_SW1C) return o & ~d;
      if (t == SMBCFG_T_SRO) return o;
      return d;
   endfunction : nxt
   // write n copies of d from register c; foreign address must be refused
   task automatic wr(input logic [6:0] a, input logic [7:0] c, d, input int n);
      smbcfg_master_inst.start();
      smbcfg_master_inst.xbyte({a, 1'b0}, 1'b1, rx, ak);
      check({7'h00, ak}, {7'h00, a != MY_A});
      if (a == MY_A) begin
         smbcfg_master_inst.xbyte(c, 1'b1, rx, ak);
         check({7'h00, ak}, 8'h00);
         for (int k = 0; k < n; k++) begin
            smbcfg_master_inst.xbyte(d, 1'b1, rx, ak);
            check({7'h00, ak}, 8'h00);
            ex[(c + k) % D] = nxt(TY[3*((c + k) % D) +: 3], ex[(c + k) % D], d);
         end
      end
      smbcfg_master_inst.stop();
   endtask : wr
   task automatic rd(input logic [7:0] c, input int n);
      smbcfg_master_inst.start();
      smbcfg_master_inst.xbyte({MY_A, 1'b0}, 1'b1, rx, ak);
      smbcfg_master_inst.xbyte(c, 1'b1, rx, ak);
      smbcfg_master_inst.start();
      smbcfg_master_inst.xbyte({MY_A, 1'b1}, 1'b1, rx, ak);
      for (int k = 0; k < n; k++) begin
         smbcfg_master_inst.xbyte(8'hFF, k == n - 1, rx, ak);
         check(rx, ex[(c + k) % D]);
      end
      smbcfg_master_inst.stop();
      for (int i = 0; i < D; i++) check(cfg[8*i +: 8], ex[i]);
   endtask : rd
   task automatic t_addr();
      check({1'b0, addr}, {1'b0, MY_A});
      strap <= 3'h2;
      wr(7'h6A, 8'h00, 8'h99, 1);
      wr(MY_A, 8'h00, 8'h3C, 1);
      check({1'b0, addr}, {1'b0, MY_A});
   endtask : t_addr
   task automatic t_burst();
      hw_data[15:8] <= 8'hE1;
      hw_load <= 8'h02;
      @(posedge clk_i);
      hw_load <= 8'h00;
      ex[1] = 8'hE1;
      wr(MY_A, 8'h00, 8'h5A, 8);
      rd(8'h00, 8);
      wr(MY_A, 8'h07, 8'hC3, 2);
      rd(8'h06, 3);
   endtask : t_burst
   task automatic t_w1c();
      hw_set[31:24] <= 8'h81;
      hw_set[39:32] <= 8'h81;
      @(posedge clk_i);
      hw_set <= '0;
      ex[3] = ex[3] | 8'h81;
      ex[4] = ex[4] | 8'h81;
      wr(MY_A, 8'h03, 8'h01, 2);
      wr(MY_A, 8'h03, 8'h00, 2);
      rd(8'h03, 2);
   endtask : t_w1c
   task automatic t_rst();
      cfg_rst_i <= 1'b1;
      @(posedge clk_i);
      cfg_rst_i <= 1'b0;
      for (int i = 0; i < D; i++) begin
         if (TY[3*i +: 3] < SMBCFG_T_SW1C) ex[i] = RV[8*i +: 8];
      end
      rd(8'h00, 8);
   endtask : t_rst
   initial begin
      rst_n_i = 1'b0;
      cfg_rst_i = 1'b0;
      strap = 3'h5;
      hw_load = '0;
      hw_data = '0;
      hw_set = '0;
      n_mismatch = 0;
      tests_run = 0;
      for (int i = 0; i < D; i++) ex[i] = RV[8*i +: 8];
      repeat (10) @(posedge clk_i);
      rst_n_i <= 1'b1;
      repeat (12) @(posedge clk_i);
      t_addr();
      t_burst();
      t_w1c();
      t_rst();
      close_out();
   end
endmodule : testbench
bind smbcfg_slave smbcfg_checker #(.DEPTH(DEPTH), .TYPES(TYPES), .RESET_VAL(RESET_VAL))
   smbcfg_checker_inst (.*);
`default_nettype wire

/* rtl/smbcfg_pkg.sv */
// Purpose: shared constants of the management-bus configuration slave
// Assumes: one byte per configuration register, byte-wide access types
`default_nettype none
package smbcfg_pkg;
   // access type codes for each configuration byte
   localparam logic [2:0] SMBCFG_T_RW   = 3'h0; // read/write
   localparam logic [2:0] SMBCFG_T_RO   = 3'h1; // loader preset; bus writes still store as read/write
   localparam logic [2:0] SMBCFG_T_HWI  = 3'h2; // hardware initialised
   localparam logic [2:0] SMBCFG_T_W1C  = 3'h3; // write one to clear
   localparam logic [2:0] SMBCFG_T_SW1C = 3'h4; // sticky write one to clear
   localparam logic [2:0] SMBCFG_T_SRW  = 3'h5; // sticky read/write
   localparam logic [2:0] SMBCFG_T_SRO  = 3'h6; // sticky read-only
   // fixed upper target address bits 6..3 = 1,1,0,1
   localparam logic [3:0] SMBCFG_ADDR_HI = 4'hD;
   localparam int         SMBCFG_STRAP_W = 3;    // strap count
   localparam logic [3:0] SMBCFG_BYTE_BITS = 4'h8; // bits per byte
   localparam logic [1:0] SMBCFG_STRAP_WAIT = 2'h3; // cycles before strap capture
endpackage : smbcfg_pkg
`default_nettype wire

/* rtl/smbcfg_slave.sv */
// Purpose: management-bus target giving a master access to config bytes
// Assumes: clk_i far faster than the bus clock; pins are open drain
// Notes: byte 1 after address selects the register, then data auto-increments
`default_nettype none
module smbcfg_slave
   import smbcfg_pkg::*;
#(
   parameter int                    DEPTH     = 16,
   parameter logic [3*DEPTH-1:0]    TYPES     = '0,
   parameter logic [8*DEPTH-1:0]    RESET_VAL = '0
) (
   input  wire logic                clk_i,
   input  wire logic                rst_n_i,     // full reset, clears sticky too
   input  wire logic                cfg_rst_i,   // non-sticky reset, one cycle
   input  wire logic                scl_i,       // bus clock pin level
   output logic                     scl_o,
   output logic                     scl_oe_n_o,
   input  wire logic                sda_i,       // bus data pin level
   output logic                     sda_o,
   output logic                     sda_oe_n_o,
   input  wire logic [smbcfg_pkg::SMBCFG_STRAP_W-1:0] strap_i, // address straps
   input  wire logic [DEPTH-1:0]    hw_load_i,   // loader/hardware byte load
   input  wire logic [8*DEPTH-1:0]  hw_data_i,   // data for hw_load_i
   input  wire logic [8*DEPTH-1:0]  hw_set_i,    // event bits, set wins
   output logic      [8*DEPTH-1:0]  cfg_o,       // register contents
   output logic      [6:0]          addr_o       // captured target address
);
   import smbcfg_pkg::*;

   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   ////////////////////////////////////////////////////////////////////
   // pin synchronisers and edge detection
   logic [SMBCFG_STRAP_W+1:0] pins_s;   // synchronised pins
   logic                      scl_d;    // previous clock level
   logic                      sda_d;    // previous data level
   wire                       scl_s  = pins_s[0];
   wire                       sda_s  = pins_s[1];
   wire [SMBCFG_STRAP_W-1:0]  strap_s = pins_s[SMBCFG_STRAP_W+1:2];
   wire                       scl_rise = scl_s & ~scl_d;
   wire                       scl_fall = ~scl_s & scl_d;
   wire                       start_c  = scl_s & scl_d & sda_d & ~sda_s;
   wire                       stop_c   = scl_s & scl_d & ~sda_d & sda_s;

   smbcfg_sync #(.W(SMBCFG_STRAP_W + 2)) u_sync (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .d_i     ({strap_i, sda_i, scl_i}),
      .q_o     (pins_s)
   );

   // previous levels for edge finding
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         // same level as the synchroniser reset, so no false fall after release
         scl_d <= 1'b0;
         sda_d <= 1'b0;
      end else begin
         scl_d <= scl_s;
         sda_d <= sda_s;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // strap capture once synchronisers have filled
   logic [1:0] strap_cnt; // cycles since release
   logic       addr_ok;   // address captured

   // capture straps a few cycles after reset, then hold
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         strap_cnt <= '0;
         addr_ok   <= 1'b0;
         addr_o    <= '0;
      end else if (!addr_ok) begin
         if (strap_cnt == SMBCFG_STRAP_WAIT) begin
            addr_ok <= 1'b1;
            addr_o  <= {SMBCFG_ADDR_HI, strap_s};
         end else begin
            strap_cnt <= strap_cnt + 2'h1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // byte-level state machine
   typedef enum logic [3:0] {
      S_IDLE, S_ADDR, S_ACK_ADDR, S_CMD, S_ACK_CMD,
      S_WDATA, S_ACK_WDATA, S_RDATA, S_RACK
   } smbcfg_state_t;

   smbcfg_state_t state;     // current phase
   logic [3:0]    bitcnt;    // bits taken this byte
   logic [7:0]    shift;     // in/out shift register
   logic [PW-1:0] ptr;       // selected register
   logic          rnw;       // read from address byte
   logic          wr_en;     // one-cycle byte write
   logic [7:0]    wr_data;   // byte being written

   wire           byte_done = (bitcnt == SMBCFG_BYTE_BITS);
   wire           addr_hit  = addr_ok && (shift[7:1] == addr_o);
   wire [7:0]     rd_byte   = cfg_o[ptr*8 +: 8];
   wire [PW-1:0]  ptr_inc   = (ptr == PW'(DEPTH - 1)) ? '0 : ptr + PW'(1);

   // bus sequencing; the block only answers, never starts
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state      <= S_IDLE;
         bitcnt     <= '0;
         shift      <= '0;
         ptr        <= '0;
         rnw        <= 1'b0;
         wr_en      <= 1'b0;
         wr_data    <= '0;
         sda_o      <= 1'b0;
         sda_oe_n_o <= 1'b1;
      end else begin
         wr_en <= 1'b0;
         if (stop_c) begin
            // stop ends any transfer and frees the line
            state      <= S_IDLE;
            sda_oe_n_o <= 1'b1;
         end else if (start_c) begin
            // start or repeated start: take the address
            state      <= S_ADDR;
            bitcnt     <= '0;
            sda_oe_n_o <= 1'b1;
         end else if (scl_rise) begin
            // sample data on the rising clock
            unique case (state)
               S_ADDR, S_CMD, S_WDATA: begin
                  shift  <= {shift[6:0], sda_s};
                  bitcnt <= bitcnt + 4'h1;
               end
               S_RACK: begin
                  // master nack ends the read
                  if (sda_s) begin
                     state <= S_IDLE;
                  end
               end
               default: begin
               end
            endcase
         end else if (scl_fall) begin
            // change data only while the clock is low
            unique case (state)
               S_ADDR: begin
                  if (byte_done) begin
                     if (addr_hit) begin
                        state      <= S_ACK_ADDR;
                        rnw        <= shift[0];
                        sda_oe_n_o <= 1'b0;
                     end else begin
                        state <= S_IDLE;
                     end
                  end
               end
               S_CMD, S_WDATA: begin
                  if (byte_done) begin
                     state      <= (state == S_CMD) ? S_ACK_CMD : S_ACK_WDATA;
                     sda_oe_n_o <= 1'b0;
                     if (state == S_CMD) begin
                        ptr <= shift[PW-1:0];
                     end else begin
                        wr_en   <= 1'b1;
                        wr_data <= shift;
                     end
                  end
               end
               S_ACK_ADDR, S_ACK_CMD, S_ACK_WDATA: begin
                  bitcnt <= '0;
                  if (state == S_ACK_ADDR && rnw) begin
                     // first read bit goes out at once
                     state      <= S_RDATA;
                     shift      <= {rd_byte[6:0], 1'b0};
                     sda_oe_n_o <= rd_byte[7];
                     bitcnt     <= 4'h1;
                  end else begin
                     state      <= (state == S_ACK_ADDR) ? S_CMD : S_WDATA;
                     sda_oe_n_o <= 1'b1;
                     if (state == S_ACK_WDATA) begin
                        ptr <= ptr_inc;
                     end
                  end
               end
               S_RDATA: begin
                  if (byte_done) begin
                     state      <= S_RACK;  // release for master ack
                     sda_oe_n_o <= 1'b1;
                     ptr        <= ptr_inc;
                  end else begin
                     sda_oe_n_o <= shift[7]; // drive low for a zero
                     shift      <= {shift[6:0], 1'b0};
                     bitcnt     <= bitcnt + 4'h1;
                  end
               end
               S_RACK: begin
                  // master acked: next byte from the new pointer
                  state      <= S_RDATA;
                  shift      <= {rd_byte[6:0], 1'b0};
                  sda_oe_n_o <= rd_byte[7];
                  bitcnt     <= 4'h1;
               end
               default: begin
               end
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // clock line: open drain, released; no stretching needed here
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         scl_o      <= 1'b0;
         scl_oe_n_o <= 1'b1;
      end else begin
         scl_o      <= 1'b0;
         scl_oe_n_o <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // configuration bytes with their access types
   for (genvar g = 0; g < DEPTH; g++) begin : g_reg
      wire [2:0] typ    = TYPES[g*3 +: 3];
      wire [7:0] cur    = cfg_o[g*8 +: 8];
      wire [7:0] rstv   = RESET_VAL[g*8 +: 8];
      wire       hit    = wr_en && (ptr == PW'(g));
      wire       sticky = (typ == SMBCFG_T_SW1C) || (typ == SMBCFG_T_SRW)
                          || (typ == SMBCFG_T_SRO);
      wire       w1c    = (typ == SMBCFG_T_W1C) || (typ == SMBCFG_T_SW1C);
      wire       no_wr  = (typ == SMBCFG_T_SRO);
      // write effect: clear on ones, or plain store
      wire [7:0] wval   = w1c ? (cur & ~wr_data) : wr_data;
      wire [7:0] base   = hw_load_i[g] ? hw_data_i[g*8 +: 8] :
                          (hit && !no_wr) ? wval : cur;
      // hardware set is ORed after load and write so it wins over a clear; non-sticky reset still overrides it
      wire [7:0] next_v = (cfg_rst_i && !sticky) ? rstv :
                          (base | hw_set_i[g*8 +: 8]);

      // byte storage; full reset clears sticky state too
      always_ff @(posedge clk_i or negedge rst_n_i) begin
         if (!rst_n_i) begin
            cfg_o[g*8 +: 8] <= RESET_VAL[g*8 +: 8];
         end else begin
            cfg_o[g*8 +: 8] <= next_v;
         end
      end
   end
endmodule : smbcfg_slave
`default_nettype wire

/* rtl/smbcfg_sync.sv */
// Purpose: two flip-flop synchroniser for pin inputs
// Assumes: each bit is an independent level
// Notes: the first stage is read only by the second
`default_nettype none
module smbcfg_sync #(
   parameter int W = 1
) (
   input  wire logic         clk_i,
   input  wire logic         rst_n_i,
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);
   logic [W-1:0] meta; // first stage

   // two-stage capture, resets to zero
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta <= '0;
         q_o  <= '0;
      end else begin
         meta <= d_i;
         q_o  <= meta;
      end
   end
endmodule : smbcfg_sync
`default_nettype wire
